// [verilog/amcc_ctrl.sv]
// Purpose: mode and conversion control
// Assumes: samples arrive on pclk
// Notes:   timing counted in modulator ticks
//
// Overview of operation
// [RULE1] Three modes picked by a two-bit field.
// [RULE2] Reset gives active mode, converters enabled, nothing running.
// [RULE3] Start honoured only in active mode with converter enabled.
// [RULE4] Standby disables converters, halts conversion, ignores starts.
// [RULE5] Host enters standby before switching clock source.
// [RULE6] Power-down unpowers analog, keeps registers, stops conversions.
// [RULE7] Host waits reference start-up after leaving power-down.
// [RULE8] One bit selects continuous or single-shot conversion.
// [RULE9] Host stops converter before changing its calibration.
// [RULE10] Go starts endless conversions; go again restarts.
// [RULE11] Halt lets conversion finish; reads one until stopped.
// [RULE12] Go wins over halt in the same write.
// [RULE13] Result kept; cleared by reset, disable, standby, power-down.
// [RULE14] Start takes effect at end of the write.
// [RULE15] Go raises ready output; old result stays readable.
// [RULE16] First result after 3*OSR+44 ticks, then every OSR.
// [RULE17] No step detection; output rate stays fixed.
// [RULE18] Single-shot: one conversion, go restarts, halt ignored.
// [RULE19] Chop alternates polarity, normal first, resets filter.
// [RULE20] Chop withholds first; outputs half rolling difference.
// [RULE21] Chop first 2*(D+3*OSR)+44, then D+3*OSR.
// [RULE22] Chop settle delay from three-bit field.
// [RULE23] Unused mode code keeps the current mode.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "amcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module amcc_ctrl import amcc_pkg::*; #(
	parameter int unsigned OSR_W = 16,
	parameter int unsigned RES_W = 24
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              mod_clk,
	input  wire logic [RES_W-1:0]  sample_a,
	input  wire logic [RES_W-1:0]  sample_b,
	output logic                   analog_power,
	output logic                   conv_active_a,
	output logic                   conv_active_b,
	output logic                   filter_reset_a,
	output logic                   filter_reset_b,
	output logic                   polarity_inv_a,
	output logic                   polarity_inv_b,
	output logic                   result_ready_n_a,
	output logic                   result_ready_n_b
);
	localparam int unsigned CNT_W = OSR_W + 4;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [CNT_W-1:0] conv_len(
		input logic [OSR_W-1:0] o,
		input logic             chop_on,
		input logic             first_on
	);
		logic [CNT_W-1:0] t;
		t = CNT_W'(o) + CNT_W'({o, 1'b0});
		if (first_on)
			t = t + CNT_W'(`AMCC_SETTLE_ADD);
		else if (!chop_on)
			t = CNT_W'(o);
		return t;
	endfunction : conv_len

	function automatic logic [CNT_W-1:0] dly_len(
		input logic [2:0] code
	);
		return CNT_W'(code) << `AMCC_DLY_SHL;
	endfunction : dly_len

	function automatic logic [RES_W-1:0] half_diff(
		input logic [RES_W-1:0] a,
		input logic [RES_W-1:0] b
	);
		logic [RES_W:0] d;
		d = {a[RES_W-1], a} - {b[RES_W-1], b};
		return d[RES_W:1];
	endfunction : half_diff

	// ----------------------------------------
	// Modulator clock sampling
	// ----------------------------------------
	logic [2:0] msync;
	logic [2:0] next_msync;
	logic       tick;

	always_comb begin
		next_msync = {msync[1:0], mod_clk};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			msync <= 3'h0;
		else
			msync <= next_msync;
	end

	// Rising edge seen only past the second stage
	assign tick = msync[1] & ~msync[2];

	// ----------------------------------------
	// Register bus and configuration
	// ----------------------------------------
	logic [1:0]       op_sel;
	logic             style;
	logic [1:0]       en;
	logic [1:0]       chop;
	logic [2:0]       dly [2];
	logic [OSR_W-1:0] osr;
	logic [1:0]       next_op_sel;
	logic             next_style;
	logic [1:0]       next_en;
	logic [1:0]       next_chop;
	logic [2:0]       next_dly [2];
	logic [OSR_W-1:0] next_osr;
	logic [31:0]      next_prdata;
	logic             next_pready;
	logic             next_pslverr;
	logic             next_analog_power;
	logic             acc;
	logic             wr;
	logic             mapped;
	logic [1:0]       go;
	logic [1:0]       halt_req;
	logic [1:0]       live;

	// Write lands on the edge that samples pready
	assign acc = psel & penable & pready;
	assign wr  = acc & pwrite;

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			`AMCC_OFF_CTRL,
			`AMCC_OFF_CONV,
			`AMCC_OFF_OSR,
			`AMCC_OFF_STAT,
			`AMCC_OFF_RES_A,
			`AMCC_OFF_RES_B: mapped = 1'b1;
			default:         mapped = 1'b0;
		endcase
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// [RULE14] Start at end of write
			go[i] = wr && paddr == `AMCC_OFF_CONV
				&& pwdata[`AMCC_B_GO + i];
			halt_req[i] = wr && paddr == `AMCC_OFF_CONV
				&& pwdata[`AMCC_B_HALT + i];
			// [RULE3] Active and enabled only
			live[i] = op_sel == AMCC_OP_ACTIVE && en[i];
		end
	end

	always_comb begin
		next_op_sel = op_sel;
		next_style  = style;
		next_en     = en;
		next_chop   = chop;
		next_dly    = dly;
		next_osr    = osr;
		if (wr && paddr == `AMCC_OFF_CTRL) begin
			// [RULE1] Two-bit mode field
			// [RULE23] Spare code ignored
			if (pwdata[`AMCC_F_OPSEL] != 2'h3)
				next_op_sel = pwdata[`AMCC_F_OPSEL];
			// [RULE8] Conversion style bit
			next_style  = pwdata[`AMCC_B_STYLE];
			next_en     = pwdata[`AMCC_B_EN +: 2];
			next_chop   = pwdata[`AMCC_B_CHOP +: 2];
			// [RULE22] Three-bit delay fields
			next_dly[0] = pwdata[`AMCC_B_DLY_A +: 3];
			next_dly[1] = pwdata[`AMCC_B_DLY_B +: 3];
		end
		if (wr && paddr == `AMCC_OFF_OSR)
			next_osr = pwdata[OSR_W-1:0];
		// [RULE6] Analog off in power-down
		next_analog_power = next_op_sel != AMCC_OP_PDOWN;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// [RULE2] Active, all enabled
			op_sel       <= AMCC_OP_ACTIVE;
			style        <= 1'b0;
			en           <= `AMCC_EN_RST;
			chop         <= 2'h0;
			dly[0]       <= 3'h0;
			dly[1]       <= 3'h0;
			osr          <= OSR_W'(`AMCC_OSR_RST);
			analog_power <= 1'b1;
		end else begin
			op_sel       <= next_op_sel;
			style        <= next_style;
			en           <= next_en;
			chop         <= next_chop;
			dly          <= next_dly;
			osr          <= next_osr;
			analog_power <= next_analog_power;
		end
	end

	// ----------------------------------------
	// Converter sequencing
	// ----------------------------------------
	amcc_st_t         st [2];
	amcc_st_t         next_st [2];
	logic [CNT_W-1:0] cnt [2];
	logic [CNT_W-1:0] next_cnt [2];
	logic [1:0]       first;
	logic [1:0]       next_first;
	logic [1:0]       halt;
	logic [1:0]       next_halt;
	logic [1:0]       pol;
	logic [1:0]       next_pol;
	logic [1:0]       rdy_n;
	logic [1:0]       next_rdy_n;
	logic [1:0]       frst;
	logic [1:0]       next_frst;
	logic [1:0]       act;
	logic [1:0]       next_act;
	logic [RES_W-1:0] prev [2];
	logic [RES_W-1:0] next_prev [2];
	logic [RES_W-1:0] res [2];
	logic [RES_W-1:0] next_res [2];
	logic [RES_W-1:0] smp [2];
	logic [CNT_W-1:0] clen [2];
	logic [CNT_W-1:0] dlen [2];
	logic [1:0]       stop;

	assign smp[0] = sample_a;
	assign smp[1] = sample_b;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_st[i]    = st[i];
			next_cnt[i]   = cnt[i];
			next_first[i] = first[i];
			next_halt[i]  = halt[i];
			next_pol[i]   = pol[i];
			next_rdy_n[i] = rdy_n[i];
			next_prev[i]  = prev[i];
			next_res[i]   = res[i];
			clen[i] = conv_len(osr, chop[i], first[i]);
			dlen[i] = dly_len(dly[i]);
			// [RULE18] Halt ignored in single-shot
			stop[i] = style | halt[i];
			// Short low pulse on each new result
			if (tick && !rdy_n[i])
				next_rdy_n[i] = 1'b1;
			if (!live[i]) begin
				// [RULE4] Forced off, starts ignored
				// [RULE13] Result cleared
				next_st[i]    = AMCC_ST_IDLE;
				next_cnt[i]   = '0;
				next_halt[i]  = 1'b0;
				next_pol[i]   = 1'b0;
				next_rdy_n[i] = 1'b1;
				next_res[i]   = '0;
			end else if (go[i]) begin
				// [RULE10] Start or restart
				// [RULE12] Go beats halt
				// [RULE15] Ready forced high
				// [RULE19] Normal polarity first
				next_st[i] = (chop[i] && dlen[i] != '0)
					? AMCC_ST_WAIT : AMCC_ST_CONV;
				next_cnt[i]   = '0;
				next_first[i] = 1'b1;
				next_halt[i]  = 1'b0;
				next_pol[i]   = 1'b0;
				next_rdy_n[i] = 1'b1;
			end else begin
				// [RULE11] Halt held until stopped
				if (halt_req[i] && !style
					&& st[i] != AMCC_ST_IDLE)
					next_halt[i] = 1'b1;
				case (st[i])
					AMCC_ST_IDLE: begin
						next_cnt[i] = '0;
					end
					AMCC_ST_WAIT: begin
						// [RULE22] Settle after go or inversion
						if (tick) begin
							next_cnt[i] = cnt[i] + 1'b1;
							if (cnt[i] + 1'b1 >= dlen[i]) begin
								next_cnt[i] = '0;
								next_st[i]  = AMCC_ST_CONV;
							end
						end
					end
					AMCC_ST_CONV: begin
						// [RULE16] Settling then OSR rate
						// [RULE21] Chop period lengths
						if (tick) begin
							next_cnt[i] = cnt[i] + 1'b1;
							if (cnt[i] + 1'b1 >= clen[i]) begin
								next_cnt[i]   = '0;
								next_first[i] = 1'b0;
								if (chop[i]) begin
									// [RULE19] Flip, filter reset
									next_pol[i]  = ~pol[i];
									next_prev[i] = smp[i];
									next_st[i] = dlen[i] != '0
										? AMCC_ST_WAIT
										: AMCC_ST_CONV;
									// [RULE20] Withhold, then pair
									if (!first[i]) begin
										next_res[i] = pol[i]
											? half_diff(prev[i], smp[i])
											: half_diff(smp[i], prev[i]);
										next_rdy_n[i] = 1'b0;
										if (stop[i]) begin
											next_st[i]   = AMCC_ST_IDLE;
											next_halt[i] = 1'b0;
										end
									end
								end else begin
									// [RULE17] No step detection
									next_res[i]   = smp[i];
									next_rdy_n[i] = 1'b0;
									// [RULE18] One result, then idle
									if (stop[i]) begin
										next_st[i]   = AMCC_ST_IDLE;
										next_halt[i] = 1'b0;
									end
								end
							end
						end
					end
					default: begin
						next_st[i] = AMCC_ST_IDLE;
					end
				endcase
			end
			// [RULE19] Filter held outside conversion
			next_frst[i] = next_st[i] != AMCC_ST_CONV
				|| (go[i] && live[i])
				|| (next_st[i] == AMCC_ST_CONV
				&& st[i] == AMCC_ST_CONV
				&& next_pol[i] != pol[i]);
			next_act[i] = next_st[i] != AMCC_ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				st[i]   <= AMCC_ST_IDLE;
				cnt[i]  <= '0;
				prev[i] <= '0;
				res[i]  <= '0;
			end
			first <= 2'h0;
			halt  <= 2'h0;
			pol   <= 2'h0;
			rdy_n <= 2'h3;
			frst  <= 2'h3;
			act   <= 2'h0;
		end else begin
			st    <= next_st;
			cnt   <= next_cnt;
			prev  <= next_prev;
			res   <= next_res;
			first <= next_first;
			halt  <= next_halt;
			pol   <= next_pol;
			rdy_n <= next_rdy_n;
			frst  <= next_frst;
			act   <= next_act;
		end
	end

	assign conv_active_a    = act[0];
	assign conv_active_b    = act[1];
	assign filter_reset_a   = frst[0];
	assign filter_reset_b   = frst[1];
	assign polarity_inv_a   = pol[0];
	assign polarity_inv_b   = pol[1];
	assign result_ready_n_a = rdy_n[0];
	assign result_ready_n_b = rdy_n[1];

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		next_pready  = psel & penable & ~pready;
		next_pslverr = next_pready & ~mapped;
		next_prdata  = 32'h0000_0000;
		if (next_pready && !pwrite) begin
			case (paddr)
				`AMCC_OFF_CTRL: begin
					next_prdata[`AMCC_F_OPSEL] = op_sel;
					next_prdata[`AMCC_B_STYLE] = style;
					next_prdata[`AMCC_B_EN +: 2] = en;
					next_prdata[`AMCC_B_CHOP +: 2] = chop;
					next_prdata[`AMCC_B_DLY_A +: 3] = dly[0];
					next_prdata[`AMCC_B_DLY_B +: 3] = dly[1];
				end
				`AMCC_OFF_CONV: begin
					next_prdata[`AMCC_B_HALT +: 2] = halt;
					next_prdata[`AMCC_B_RUN +: 2]  = act;
				end
				`AMCC_OFF_OSR: begin
					next_prdata[OSR_W-1:0] = osr;
				end
				`AMCC_OFF_STAT: begin
					next_prdata[`AMCC_F_OPSEL] = op_sel;
					next_prdata[`AMCC_B_PWR] = analog_power;
					next_prdata[`AMCC_B_RDYN +: 2] = rdy_n;
				end
				`AMCC_OFF_RES_A: begin
					next_prdata[RES_W-1:0] = res[0];
				end
				`AMCC_OFF_RES_B: begin
					next_prdata[RES_W-1:0] = res[1];
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Registered answer costs one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end
endmodule : amcc_ctrl
`default_nettype wire

// [inc/amcc_defs.svh]
// Purpose: offsets, fields, resets, timing
// Assumes: APB, byte addresses
// Notes:   counts in modulator periods
`ifndef AMCC_DEFS_SVH
`define AMCC_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AMCC_OFF_CTRL   8'h00
`define AMCC_OFF_CONV   8'h04
`define AMCC_OFF_OSR    8'h08
`define AMCC_OFF_STAT   8'h0C
`define AMCC_OFF_RES_A  8'h10
`define AMCC_OFF_RES_B  8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define AMCC_F_OPSEL    1:0
`define AMCC_B_STYLE    2
`define AMCC_B_EN       3
`define AMCC_B_CHOP     5
`define AMCC_B_DLY_A    7
`define AMCC_B_DLY_B    10
`define AMCC_B_GO       0
`define AMCC_B_HALT     2
`define AMCC_B_RUN      4
`define AMCC_B_PWR      2
`define AMCC_B_RDYN     3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define AMCC_OSR_RST    16'h0100
`define AMCC_EN_RST     2'h3
`define AMCC_SETTLE_ADD 44
`define AMCC_DLY_SHL    6
`endif

// [inc/amcc_pkg.sv]
// Purpose: shared types
// Assumes: nothing
// Notes:   codes 2'h3 of the mode field unused
package amcc_pkg;
	typedef enum logic [1:0] {
		AMCC_OP_ACTIVE  = 2'h0,
		AMCC_OP_STANDBY = 2'h1,
		AMCC_OP_PDOWN   = 2'h2
	} amcc_op_t;
	typedef enum logic [2:0] {
		AMCC_ST_IDLE = 3'h1,
		AMCC_ST_WAIT = 3'h2,
		AMCC_ST_CONV = 3'h4
	} amcc_st_t;
endpackage : amcc_pkg

// [tb/amcc_ctrl_properties.sv]
// Purpose: port checks for amcc_ctrl
// Assumes: one pclk domain
// Notes:   mode and enables shadowed from APB
`include "amcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module amcc_ctrl_properties import amcc_pkg::*; #(
	parameter int unsigned RES_W = 24
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             mod_clk,
	input wire logic [RES_W-1:0] sample_a,
	input wire logic [RES_W-1:0] sample_b,
	input wire logic             analog_power,
	input wire logic             conv_active_a,
	input wire logic             conv_active_b,
	input wire logic             filter_reset_a,
	input wire logic             filter_reset_b,
	input wire logic             polarity_inv_a,
	input wire logic             polarity_inv_b,
	input wire logic             result_ready_n_a,
	input wire logic             result_ready_n_b
);
	// ----
	// Shadow
	// ----
	logic [1:0] mode_sh, next_mode_sh, en_sh, next_en_sh;
	logic       wr_w, map_ok, ok_a;
	assign wr_w = psel && penable && pready && pwrite;
	assign map_ok = paddr[1:0] == 2'h0 && paddr <= 8'h14;
	assign ok_a = mode_sh == 2'h0 && en_sh[0];
	always_comb begin
		next_mode_sh = mode_sh;
		next_en_sh = en_sh;
		if (wr_w && paddr == `AMCC_OFF_CTRL) begin
			next_en_sh = pwdata[4:3];
			// Code 3 dropped by the block too
			if (pwdata[1:0] != 2'h3)
				next_mode_sh = pwdata[1:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sh <= 2'h0;
			en_sh <= 2'h3;
		end else begin
			mode_sh <= next_mode_sh;
			en_sh <= next_en_sh;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !$past(penable);
	endsequence
	sequence s_ack;
		!pready ##1 pready;
	endsequence
	sequence s_go_a;
		wr_w && paddr == `AMCC_OFF_CONV && pwdata[0] && ok_a;
	endsequence
	a_ack_wait: assert property (s_access |-> s_ack)
		else $error("pready not after one wait state");
	a_ack_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == !map_ok)
		else $error("pslverr wrong for address");
	a_power_mode: assert property ($stable(mode_sh)[*2] |->
		analog_power == (mode_sh != 2'h2))
		else $error("analog power wrong for mode");
	a_go_start: assert property (s_go_a |-> ##[1:2] conv_active_a)
		else $error("go did not start converter");
	a_off_idle: assert property ((!ok_a)[*3] |->
		!conv_active_a && result_ready_n_a)
		else $error("converter runs while off");
	a_ready_go: assert property (s_go_a |-> ##1 result_ready_n_a[*4])
		else $error("ready not high after go");
	a_ready_back: assert property ($fell(result_ready_n_a) |->
		##[1:12] result_ready_n_a)
		else $error("ready low past one tick");
	a_filter_idle: assert property ((!conv_active_a)[*2] |->
		filter_reset_a)
		else $error("filter free while idle");
	a_chop_flip: assert property ($changed(polarity_inv_a) &&
		conv_active_a |-> ##[0:1] filter_reset_a)
		else $error("no filter reset at flip");
endmodule : amcc_ctrl_properties
bind amcc_ctrl amcc_ctrl_properties #(.RES_W(RES_W))
	amcc_ctrl_properties_i (.*);
`default_nettype wire

// [tb/amcc_mod_model.sv]
// Purpose: modulator side stand-in
// Assumes: filter word fixed per polarity
// Notes:   inverted input flips sign of v only
`timescale 1ns/1ps
`default_nettype none
module amcc_mod_model import amcc_pkg::*; #(
	parameter int unsigned RES_W = 24
) (
	output var logic              mod_clk,
	output logic      [RES_W-1:0] sample_a,
	output logic      [RES_W-1:0] sample_b,
	input  wire logic             polarity_inv_a,
	input  wire logic             polarity_inv_b,
	input  wire logic [RES_W-1:0] v,
	input  wire logic [RES_W-1:0] off
);
	// Free running, phase unrelated to pclk
	initial begin
		mod_clk = 1'b0;
		#7;
		forever #80 mod_clk = ~mod_clk;
	end
	assign sample_a = polarity_inv_a ? off - v : off + v;
	assign sample_b = polarity_inv_b ? off - v : off + v;
endmodule : amcc_mod_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for amcc_ctrl
// Assumes: APB master, free modulator clock
// Notes:   OSR set to 4 so runs stay short
`include "amcc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top import amcc_pkg::*;;
	typedef struct {
		string       n;
		logic [32:0] v;
	} amcc_exp_t;
	localparam int REF_WAIT = 50;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        mod_clk, analog_power, rdy_q;
	logic        conv_active_a, conv_active_b, filter_reset_a;
	logic        filter_reset_b, polarity_inv_a, polarity_inv_b;
	logic        result_ready_n_a, result_ready_n_b;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [23:0] sample_a, sample_b, v, off;
	amcc_exp_t   qr[$], qt[$];
	int          errors, n_tests, ticks, k;
	amcc_ctrl amcc_ctrl_i (.*);
	amcc_mod_model amcc_mod_model_i (.*);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge mod_clk) ticks++;
	// ----
	// Tasks
	// ----
	task automatic stop_test;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(ref amcc_exp_t q[$], input logic [32:0] s,
			input int tol);
		amcc_exp_t e;
		if (q.size() == 0)
			return;
		e = q.pop_front();
		n_tests++;
		if (((s === e.v) || (s + tol - e.v <= 2 * tol)) !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %s exp %0h seen %0h", e.n, e.v, s);
		end
	endtask : chk
	task automatic pin(string n, logic s, logic e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %0h seen %0h", n, e, s);
		end
	endtask : pin
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			$display("CHECK FAILED pready exp 1 seen 0");
			stop_test;
		end
		@(posedge pclk);
	endtask : xfer
	task automatic rd(string n, logic [7:0] a, logic [31:0] d, bit e = 0);
		qr.push_back('{n, {e, d}});
		xfer(1'b0, a, 32'h0);
	endtask : rd
	task automatic go(logic [31:0] d);
		xfer(1'b1, `AMCC_OFF_CONV, d);
		ticks = 0;
	endtask : go
	task automatic ex(string n, int k);
		qt.push_back('{n, 33'(k)});
	endtask : ex
	task automatic drain;
		int n;
		n = 0;
		while (qt.size() > 0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		if (qt.size() > 0) begin
			errors++;
			$display("CHECK FAILED %s exp result seen none", qt[0].n);
			stop_test;
		end
	endtask : drain
	// ----
	// Monitor
	// ----
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(qr, {pslverr, prdata}, 0);
		// Tick slack covers sync and phase
		if (result_ready_n_a === 1'b0 && rdy_q === 1'b1) begin
			chk(qt, 33'(ticks), 2);
			ticks = 0;
		end
		rdy_q = result_ready_n_a;
	end
	// ----
	// Sequence
	// ----
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		rdy_q = 1'b1;
		v = 24'($urandom(99970));
		off = 24'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		v <= 24'($urandom % 65536);
		off <= 24'($urandom % 256);
		@(posedge pclk);
		rd("ctrl", `AMCC_OFF_CTRL, 32'h18);
		rd("osr", `AMCC_OFF_OSR, 32'h100);
		rd("stat", `AMCC_OFF_STAT, 32'h1C);
		rd("conv", `AMCC_OFF_CONV, 32'h0);
		rd("res_a", `AMCC_OFF_RES_A, 32'h0);
		rd("unmapped", 8'h18, 32'h0, 1'b1);
		$display("test reset done");
		xfer(1'b1, `AMCC_OFF_OSR, 32'h4);
		go(32'h1);
		ex("first", 56);
		ex("next", 4);
		drain;
		rd("res_a", `AMCC_OFF_RES_A, 32'(off + v));
		go(32'h5);
		ex("restart", 56);
		drain;
		xfer(1'b1, `AMCC_OFF_CONV, 32'h4);
		rd("halting", `AMCC_OFF_CONV, 32'h14);
		ex("last", 4);
		drain;
		rd("halted", `AMCC_OFF_CONV, 32'h0);
		rd("kept", `AMCC_OFF_RES_A, 32'(off + v));
		$display("test continuous done");
		xfer(1'b1, `AMCC_OFF_CTRL, 32'h1C);
		v <= 24'($urandom % 65536);
		go(32'h1);
		xfer(1'b1, `AMCC_OFF_CONV, 32'h4);
		ex("single", 56);
		drain;
		rd("ss idle", `AMCC_OFF_CONV, 32'h0);
		rd("ss res", `AMCC_OFF_RES_A, 32'(off + v));
		$display("test single done");
		xfer(1'b1, `AMCC_OFF_CTRL, 32'hB8);
		v <= 24'($urandom % 65536);
		go(32'h1);
		ex("chop first", 196);
		ex("chop next", 76);
		drain;
		rd("chop res", `AMCC_OFF_RES_A, 32'(v));
		$display("test chop done");
		xfer(1'b1, `AMCC_OFF_CTRL, 32'hB9);
		rd("sb stat", `AMCC_OFF_STAT, 32'h1D);
		rd("sb res", `AMCC_OFF_RES_A, 32'h0);
		go(32'h1);
		rd("sb conv", `AMCC_OFF_CONV, 32'h0);
		xfer(1'b1, `AMCC_OFF_CTRL, 32'h1A);
		rd("pd stat", `AMCC_OFF_STAT, 32'h1A);
		xfer(1'b1, `AMCC_OFF_CTRL, 32'h1B);
		rd("bad mode", `AMCC_OFF_CTRL, 32'h1A);
		xfer(1'b1, `AMCC_OFF_CTRL, 32'h10);
		repeat (REF_WAIT) @(posedge pclk);
		go(32'h3);
		rd("en gate", `AMCC_OFF_CONV, 32'h20);
		rd("dis res", `AMCC_OFF_RES_A, 32'h0);
		$display("test modes done");
		// Converter b pins, bounded wait for its result
		k = 0;
		while (result_ready_n_b !== 1'b0 && k < 1000) begin
			@(posedge pclk);
			k++;
		end
		ex("b first", 56);
		chk(qt, 33'(ticks), 2);
		pin("b ready", result_ready_n_b, 1'b0);
		pin("b active", conv_active_b, 1'b1);
		pin("b filter", filter_reset_b, 1'b0);
		pin("b pol", polarity_inv_b, 1'b0);
		rd("res_b", `AMCC_OFF_RES_B, 32'(off + v));
		$display("test converter b done");
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
